/* File: rtl/itbt_pkg.sv */
// Constants and types for the interval and time base timer.
// Assumes one 200 MHz system clock and a watch clock sampled as a pin.
package itbt_pkg;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_IRQ_EN = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PORT_MODE = 8'h10;
  localparam logic [7:0] MODE_RST = 8'h10;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam int MODE_RSVD_BIT = 4;
  localparam int MODE_SEL_BIT = 3;
  localparam int HOLD_BIT = 2;
  localparam int OUTSEL_LSB = 5;
  localparam int OVF_FLAG_BIT = 0;
  localparam int CLK_OUT_EN_BIT = 0;
  localparam int SYS_PRE_W = 13;
  localparam int WATCH_PRE_W = 7;
  localparam int OUT_TAP_SLOW = 4;
  localparam int CLK_MHZ = 200;
  localparam int WATCH_HZ = 32768;
  typedef enum logic [2:0] {
    ITBT_ACTIVE = 3'h0,
    ITBT_SLEEP = 3'h1,
    ITBT_WATCH = 3'h3,
    ITBT_SUBACTIVE = 3'h2,
    ITBT_SUBSLEEP = 3'h6,
    ITBT_STANDBY = 3'h7
  } itbt_power_e;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } itbt_apb_req_s;
endpackage : itbt_pkg

/* File: rtl/itbt_timer.sv */
// Interval and time base timer with APB registers and a clock output pin.
// Assumes an APB master on clk_i and a 32.768 kHz watch clock on a pin.
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module itbt_timer (
  input wire logic clk_i,                          // System clock.
  input wire logic rst_i,                          // Synchronous reset, high.
  input wire itbt_pkg::itbt_apb_req_s apb_i,       // APB request.
  output logic pready_o,                           // APB ready.
  output logic pslverr_o,                          // APB error.
  output logic [31:0] prdata_o,                    // APB read data.
  input wire logic watch_clk_i,                    // Watch clock pin.
  input wire itbt_pkg::itbt_power_e power_mode_i,  // Low-power mode.
  output logic clock_out_pin_o,                    // Divided clock output.
  output logic irq_o                               // Overflow interrupt.
);

  ////////////////////////////////////////////////////////////////////////
  // Prescaler tap selection.

  function automatic logic [3:0] sys_tap_exp(input logic [2:0] code);
    logic [3:0] e;
    e = 4'hD;
    unique case (code)
      3'h0: e = 4'hD;
      3'h1: e = 4'hC;
      3'h2: e = 4'hB;
      3'h3: e = 4'h9;
      3'h4: e = 4'h8;
      3'h5: e = 4'h7;
      3'h6: e = 4'h5;
      3'h7: e = 4'h3;
    endcase
    return e;
  endfunction : sys_tap_exp

  // The counter sees the watch prescaler at 1/128, which is 256 Hz;
  // shorter taps shorten the 256-count overflow period.
  function automatic logic [2:0] tb_tap_exp(input logic [1:0] code);
    logic [2:0] e;
    e = 3'h7;
    unique case (code)
      2'h0: e = 3'h7;
      2'h1: e = 3'h6;
      2'h2: e = 3'h5;
      2'h3: e = 3'h2;
    endcase
    return e;
  endfunction : tb_tap_exp

  ////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] mode_r;
  logic [7:0] count_r;
  logic ovf_flag_r;
  logic ovf_en_r;
  logic clk_out_en_r;
  logic [itbt_pkg::SYS_PRE_W-1:0] pss_r;
  logic [itbt_pkg::WATCH_PRE_W-1:0] psw_r;
  logic wclk_s1_r;
  logic wclk_s2_r;
  logic wclk_s3_r;
  logic clk_out_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire logic setup_ph;
  wire logic access_ph;
  wire logic wr_acc;
  wire logic hit_mode;
  wire logic hit_count;
  wire logic hit_stat;
  wire logic hit_en;
  wire logic hit_port;
  wire logic unmapped;

  assign setup_ph = apb_i.psel & ~apb_i.penable;
  assign access_ph = apb_i.psel & apb_i.penable;
  assign wr_acc = access_ph & apb_i.pwrite;
  assign hit_mode = apb_i.paddr == itbt_pkg::OFS_MODE;
  assign hit_count = apb_i.paddr == itbt_pkg::OFS_COUNT;
  assign hit_stat = apb_i.paddr == itbt_pkg::OFS_IRQ_STAT;
  assign hit_en = apb_i.paddr == itbt_pkg::OFS_IRQ_EN;
  assign hit_port = apb_i.paddr == itbt_pkg::OFS_PORT_MODE;
  assign unmapped = ~(hit_mode | hit_count | hit_stat | hit_en | hit_port);

  ////////////////////////////////////////////////////////////////////////
  // Power mode qualifiers.

  wire logic pm_active;
  wire logic pm_sleep;
  wire logic pm_subactive;
  wire logic pm_subsleep;
  wire logic sys_run;
  wire logic tb_run;
  wire logic watch_out_run;
  wire logic mode_wr_ok;

  assign pm_active = power_mode_i == itbt_pkg::ITBT_ACTIVE;
  assign pm_sleep = power_mode_i == itbt_pkg::ITBT_SLEEP;
  assign pm_subactive = power_mode_i == itbt_pkg::ITBT_SUBACTIVE;
  assign pm_subsleep = power_mode_i == itbt_pkg::ITBT_SUBSLEEP;
  assign sys_run = pm_active | pm_sleep;
  assign tb_run = power_mode_i != itbt_pkg::ITBT_STANDBY;
  assign watch_out_run = sys_run | pm_subactive | pm_subsleep;
  assign mode_wr_ok = pm_active | pm_subactive;

  ////////////////////////////////////////////////////////////////////////
  // Mode fields.

  wire logic tb_mode;
  wire logic hold;
  wire logic [2:0] iv_code;
  wire logic [1:0] tb_code;
  wire logic [2:0] out_sel;

  assign tb_mode = mode_r[itbt_pkg::MODE_SEL_BIT];
  assign hold = tb_mode & mode_r[itbt_pkg::HOLD_BIT];
  assign iv_code = mode_r[2:0];
  assign tb_code = mode_r[1:0];
  assign out_sel = mode_r[itbt_pkg::OUTSEL_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////
  // Count enables from prescaler taps.

  wire logic wclk_rise;
  wire logic [itbt_pkg::SYS_PRE_W-1:0] sys_mask;
  wire logic [itbt_pkg::WATCH_PRE_W-1:0] tb_mask;
  wire logic sys_tick;
  wire logic tb_tick;
  wire logic count_en;
  wire logic overflow;

  assign wclk_rise = wclk_s2_r & ~wclk_s3_r;
  assign sys_mask = (itbt_pkg::SYS_PRE_W)'((14'h1 << sys_tap_exp(iv_code)) - 14'h1);
  assign tb_mask = (itbt_pkg::WATCH_PRE_W)'((8'h1 << tb_tap_exp(tb_code)) - 8'h1);
  assign sys_tick = (pss_r & sys_mask) == sys_mask;
  assign tb_tick = wclk_rise & ((psw_r & tb_mask) == tb_mask);
  assign count_en = tb_mode ? (tb_tick & tb_run & ~hold)
                            : (sys_tick & sys_run);
  assign overflow = count_en & (count_r == itbt_pkg::COUNT_MAX);

  ////////////////////////////////////////////////////////////////////////
  // Next values.

  logic [7:0] mode_nxt;
  logic [7:0] count_nxt;
  logic ovf_flag_nxt;

  always_comb
  begin
    mode_nxt = mode_r;
    if (wr_acc & hit_mode & mode_wr_ok)
    begin
      mode_nxt = apb_i.pwdata[7:0];
    end
    mode_nxt[itbt_pkg::MODE_RSVD_BIT] = 1'b1;
  end

  always_comb
  begin
    count_nxt = count_r;
    if (hold)
    begin
      count_nxt = itbt_pkg::COUNT_RST;
    end
    else if (count_en)
    begin
      count_nxt = count_r + 8'h01;
    end
  end

  always_comb
  begin
    ovf_flag_nxt = ovf_flag_r;
    if (wr_acc & hit_stat & apb_i.pwdata[itbt_pkg::OVF_FLAG_BIT])
    begin
      ovf_flag_nxt = 1'b0;
    end
    if (overflow)
    begin
      ovf_flag_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock output selection.

  wire logic [2:0] out_tap;
  wire logic out_src;
  wire logic out_allowed;

  assign out_tap = 3'(itbt_pkg::OUT_TAP_SLOW) - {1'b0, out_sel[1:0]};
  assign out_src = out_sel[2] ? psw_r[out_tap] : pss_r[out_tap];
  assign out_allowed = out_sel[2] ? watch_out_run : sys_run;

  ////////////////////////////////////////////////////////////////////////
  // Read data.

  logic [31:0] rd_data;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_mode)
    begin
      rd_data[7:0] = mode_r;
    end
    else if (hit_count & ~pm_subactive)
    begin
      rd_data[7:0] = count_r;
    end
    else if (hit_stat)
    begin
      rd_data[itbt_pkg::OVF_FLAG_BIT] = ovf_flag_r;
    end
    else if (hit_en)
    begin
      rd_data[itbt_pkg::OVF_FLAG_BIT] = ovf_en_r;
    end
    else if (hit_port)
    begin
      rd_data[itbt_pkg::CLK_OUT_EN_BIT] = clk_out_en_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Watch clock synchroniser.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wclk_s1_r <= 1'b0;
      wclk_s2_r <= 1'b0;
      wclk_s3_r <= 1'b0;
    end
    else
    begin
      wclk_s1_r <= watch_clk_i;
      wclk_s2_r <= wclk_s1_r;
      wclk_s3_r <= wclk_s2_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Prescalers.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pss_r <= '0;
    end
    else
    begin
      pss_r <= pss_r + (itbt_pkg::SYS_PRE_W)'(1);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i | hold)
    begin
      psw_r <= '0;
    end
    else if (wclk_rise)
    begin
      psw_r <= psw_r + (itbt_pkg::WATCH_PRE_W)'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode, counter and interrupt registers.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_r <= itbt_pkg::MODE_RST;
      count_r <= itbt_pkg::COUNT_RST;
      ovf_flag_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      count_r <= count_nxt;
      ovf_flag_r <= ovf_flag_nxt;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ovf_en_r <= 1'b0;
      clk_out_en_r <= 1'b0;
    end
    else
    begin
      if (wr_acc & hit_en)
      begin
        ovf_en_r <= apb_i.pwdata[itbt_pkg::OVF_FLAG_BIT];
      end
      if (wr_acc & hit_port)
      begin
        clk_out_en_r <= apb_i.pwdata[itbt_pkg::CLK_OUT_EN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output flops.

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      clk_out_r <= 1'b0;
    end
    else
    begin
      clk_out_r <= clk_out_en_r & out_allowed & out_src;
    end
  end

  // Read data and error are captured in the setup cycle, so the access
  // phase can complete with no wait state.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_r <= apb_i.pwrite ? 32'h0000_0000 : rd_data;
      pslverr_r <= unmapped;
    end
  end

  assign pready_o = 1'b1;
  assign pslverr_o = access_ph & pslverr_r;
  assign prdata_o = prdata_r;
  assign clock_out_pin_o = clk_out_r;
  assign irq_o = ovf_flag_r & ovf_en_r;

endmodule : itbt_timer

`default_nettype wire

/* File: verification/itbt_asserts.sv */
// Port assertions for the interval and time base timer.
// Assumes it is bound to itbt_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module itbt_asserts (
  input wire logic clk_i,  // Clock.
  input wire logic rst_i,  // Reset.
  input wire itbt_pkg::itbt_apb_req_s apb_i,  // Request.
  input wire logic pready_o,  // Ready.
  input wire logic pslverr_o,  // Error.
  input wire logic [31:0] prdata_o,  // Read data.
  input wire logic watch_clk_i,  // Watch pin.
  input wire itbt_pkg::itbt_power_e power_mode_i,  // Power mode.
  input wire logic clock_out_pin_o,  // Clock out.
  input wire logic irq_o  // Interrupt.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire acc_w = apb_i.psel & apb_i.penable;
  wire rd_w = acc_w & ~apb_i.pwrite;
  wire map_w = (apb_i.paddr <= itbt_pkg::OFS_PORT_MODE) & (apb_i.paddr[1:0] == 2'h0);
  wire clr_w = acc_w & apb_i.pwrite & (apb_i.paddr[7:3] == 5'h01);
  ////////////////////////////////////////
  ready_high_a: assert property (pready_o) else $error("ready low");
  reset_quiet_a: assert property ($past(rst_i) |-> !irq_o && !clock_out_pin_o && !pslverr_o)
    else $error("outputs active after reset");
  rsvd_one_a: assert property (rd_w && apb_i.paddr == itbt_pkg::OFS_MODE |-> prdata_o[4])
    else $error("reserved mode bit read zero");
  irq_hold_a: assert property (irq_o && !clr_w |=> irq_o)
    else $error("interrupt dropped without software");
  sub_zero_a: assert property (rd_w && apb_i.paddr == itbt_pkg::OFS_COUNT
    && power_mode_i == itbt_pkg::ITBT_SUBACTIVE && $past(power_mode_i) == itbt_pkg::ITBT_SUBACTIVE
    |-> prdata_o[7:0] == 8'h00) else $error("count readable in subactive");
  err_phase_a: assert property (!acc_w |-> !pslverr_o) else $error("error outside access");
  unmapped_err_a: assert property (acc_w && !map_w |-> pslverr_o) else $error("unmapped not refused");
  rdata_hold_a: assert property (acc_w |=> $stable(prdata_o)) else $error("read data moved");
  upper_zero_a: assert property (acc_w |-> prdata_o[31:8] == 24'h000000) else $error("upper bits set");
  cover property ($rose(irq_o));
  cover property ($rose(clock_out_pin_o));
  cover property (pslverr_o);
endmodule : itbt_asserts

bind itbt_timer itbt_asserts u_itbt_asserts (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb_i),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .prdata_o(prdata_o), .watch_clk_i(watch_clk_i),
  .power_mode_i(power_mode_i), .clock_out_pin_o(clock_out_pin_o), .irq_o(irq_o));
`default_nettype wire

/* File: verification/test_itbt_timer.sv */
// Self-checking bench for the interval and time base timer.
// Assumes the package and itbt_timer are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_itbt_timer;
  localparam logic [7:0] AM = itbt_pkg::OFS_MODE;
  localparam logic [7:0] AC = itbt_pkg::OFS_COUNT;
  localparam logic [7:0] AS = itbt_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] AE = itbt_pkg::OFS_IRQ_EN;
  localparam logic [7:0] AP = itbt_pkg::OFS_PORT_MODE;
  logic clk_i, rst_i, clock_out_pin_o, irq_o, pready_o, pslverr_o, err;
  logic watch_clk_i = 1'b0;
  logic [31:0] prdata_o, q;
  logic [7:0] c0, dv;
  itbt_pkg::itbt_apb_req_s apb_i;
  itbt_pkg::itbt_power_e power_mode_i;
  int bad_count, samples_checked, e, n;
  int wcnt = 0;
  int sh[8] = '{13, 12, 11, 9, 8, 7, 5, 3};
  int tb[4] = '{7, 6, 5, 2};

  itbt_timer u_itbt_timer (.clk_i(clk_i), .rst_i(rst_i), .apb_i(apb_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .prdata_o(prdata_o), .watch_clk_i(watch_clk_i),
    .power_mode_i(power_mode_i), .clock_out_pin_o(clock_out_pin_o), .irq_o(irq_o));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // The watch pin runs at one eighth of the system clock to keep runs short.
  always @(posedge clk_i)
  begin
    wcnt <= (wcnt + 1) % 4;
    if (wcnt == 3)
      watch_clk_i <= ~watch_clk_i;
  end
  ////////////////////////////////////////
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input int lo, input int hi);
    samples_checked++;
    if ((g >= lo && g <= hi) !== 1'b1)
    begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, lo);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    apb_i <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_i);
    apb_i.penable <= 1'b1;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (pready_o !== 1'b1 && k < 16);
    q = prdata_o;
    err = pslverr_o;
    apb_i.psel <= 1'b0;
    apb_i.penable <= 1'b0;
    if (pready_o !== 1'b1)
    begin
      bad_count++;
      give_verdict;
    end
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic edges;
    logic p;
    e = 0;
    p = clock_out_pin_o;
    repeat (1024)
    begin
      @(posedge clk_i);
      e += int'(clock_out_pin_o && !p);
      p = clock_out_pin_o;
    end
  endtask : edges

  // Measures count advance over a wait, in ticks.
  task automatic span(input int cyc);
    rd(AC);
    c0 = q[7:0];
    repeat (cyc) @(posedge clk_i);
    rd(AC);
    dv = q[7:0] - c0;
  endtask : span
  ////////////////////////////////////////
  initial
  begin
    rst_i = 1'b1;
    apb_i = '0;
    power_mode_i = itbt_pkg::ITBT_ACTIVE;
    bad_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(AM);
    chk(q, 8'h10, 8'h10);
    rd(AC);
    chk(q, 8'h00, 8'h00);
    rd(8'h20);
    chk({q[30:0], err}, 1, 1);
    wr(AM, 32'h07);
    rd(AM);
    chk(q, 8'h17, 8'h17);
    for (int i = 0; i < 8; i++)
    begin
      wr(AM, i);
      span(4 << sh[i]);
      chk(dv, 3, 5);
    end
    wr(AE, 32'h0);
    wr(AS, 32'h1);
    repeat (2100) @(posedge clk_i);
    rd(AS);
    chk({q[0], irq_o}, 2, 2);
    wr(AE, 32'h1);
    chk(irq_o, 1, 1);
    // Hold the counter so no overflow can land between the clear and the read.
    wr(AM, 32'h0C);
    wr(AS, 32'h1);
    rd(AS);
    chk({q[0], irq_o}, 0, 0);
    wr(AM, 32'h07);
    for (n = 0; n < 2100 && irq_o !== 1'b1; n++) @(posedge clk_i);
    if (n == 2100)
    begin
      bad_count++;
      give_verdict;
    end
    rd(AC);
    chk(q, 0, 2);
    wr(AS, 32'h1);
    wr(AM, 32'h0C);
    span(50);
    chk(q, 0, 0);
    for (int k = 0; k < 4; k++)
    begin
      wr(AM, 8'h08 | k);
      span(32 << tb[k]);
      chk(dv, 3, 5);
    end
    power_mode_i <= itbt_pkg::ITBT_WATCH;
    span(320);
    chk(dv, 9, 11);
    power_mode_i <= itbt_pkg::ITBT_STANDBY;
    span(320);
    chk(dv, 0, 1);
    power_mode_i <= itbt_pkg::ITBT_ACTIVE;
    // The slowest tap in the first window and the code 6 tap in the second keep the two short running windows to one tick at most.
    wr(AM, 32'h00);
    rd(AC);
    c0 = q[7:0];
    power_mode_i <= itbt_pkg::ITBT_SUBACTIVE;
    rd(AC);
    chk(q, 0, 0);
    wr(AM, 32'h06);
    repeat (200) @(posedge clk_i);
    power_mode_i <= itbt_pkg::ITBT_SLEEP;
    wr(AM, 32'h05);
    power_mode_i <= itbt_pkg::ITBT_ACTIVE;
    rd(AC);
    dv = q[7:0] - c0;
    chk(dv, 0, 1);
    rd(AM);
    chk(q, 8'h16, 8'h16);
    wr(AP, 32'h1);
    for (int c = 0; c < 8; c++)
    begin
      wr(AM, c << 5);
      edges;
      n = (c < 4) ? (32 << c) : (4 << (c - 4));
      chk(e, n - 1, n + 1);
    end
    power_mode_i <= itbt_pkg::ITBT_SUBACTIVE;
    edges;
    chk(e, 31, 33);
    wr(AM, 32'h60);
    edges;
    chk(e, 0, 0);
    power_mode_i <= itbt_pkg::ITBT_ACTIVE;
    wr(AP, 32'h0);
    edges;
    chk(e, 0, 0);
    chk(clock_out_pin_o, 0, 0);
    give_verdict;
  end
endmodule : test_itbt_timer
`default_nettype wire
